// ==== src/usp_params.svh ====
// Purpose: named offsets, fields, reset values and timing for the pin block
// Assumes: 32-bit apb data, one word per register
// Notes: definitions only
`ifndef USP_PARAMS_SVH
`define USP_PARAMS_SVH
// ==========================================================
// register byte addresses
`define USP_A_STAT_CFG   12'h000
`define USP_A_FUNC_SEL   12'h004
`define USP_A_GPIO_DIR   12'h008
`define USP_A_GPIO_OUT   12'h00c
`define USP_A_GPIO_PU    12'h010
`define USP_A_GPIO_IN    12'h014
`define USP_A_MODEM_CTL  12'h018
`define USP_A_STATUS     12'h01c
// ==========================================================
// status pin config fields
`define USP_SC_POL       0
`define USP_SC_RST       1
`define USP_SC_SUSP      2
`define USP_SC_UNSAFE    3
`define USP_SC_RESET     4'h5
// ==========================================================
// pin indices
`define USP_P_RTS        0
`define USP_P_CTS        1
`define USP_P_DTR        2
`define USP_P_DSR        3
`define USP_P_CD         4
`define USP_P_RING       5
`define USP_P_RXACT      6
`define USP_P_TXACT      7
// ==========================================================
// reset values and limits
`define USP_FUNC_RESET   24'h000000
`define USP_DIR_RESET    8'h00
`define USP_OUT_RESET    8'h00
`define USP_PU_RESET     8'hff
`define USP_MC_RESET     2'h0
`define USP_ONE_LOAD     8'h32
// ==========================================================
// activity toggle timing
`define USP_ACT_TOGGLE_MS 100
`define USP_CLK_MHZ       200
`define USP_ACT_CYC       (`USP_ACT_TOGGLE_MS * `USP_CLK_MHZ * 1000)
`endif

// ==== src/usp_pkg.sv ====
// Purpose: types shared by the pin block
// Assumes: nothing
// Notes: function codes are software visible
package usp_pkg;
	// ==========================================================
	// per-pin function select
	typedef enum logic [2:0] {
		USP_F_GPIO   = 3'h0,
		USP_F_MODEM  = 3'h1,
		USP_F_RS485  = 3'h2,
		USP_F_WAKE   = 3'h3,
		USP_F_ACT    = 3'h4
	} usp_fsel_t;
	typedef logic [7:0] usp_pins_t;
endpackage

// ==== src/usp_act_toggle.sv ====
// Purpose: activity indicator that toggles at a slow fixed interval
// Assumes: busy comes from logic on pclk
// Notes: counter restarts whenever busy drops
`timescale 1ns/1ps
`include "usp_params.svh"
module usp_act_toggle #(
	parameter int unsigned CYC = `USP_ACT_CYC
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic busy,
	output logic      toggle_r
);
	// ==========================================================
	// interval counter
	logic [31:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 32'h0;
		end else if (!busy || cnt_r == CYC - 1) begin
			cnt_r <= 32'h0;
		end else begin
			cnt_r <= cnt_r + 32'h1;
		end
	end

	// idle means the pin stays where it is
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_r <= 1'b0;
		end else if (busy && cnt_r == CYC - 1) begin
			toggle_r <= ~toggle_r;
		end
	end
endmodule

// ==== src/usp_pin_logic.sv ====
// Purpose: bus status output and multifunction pin logic of one channel
// Assumes: usb and uart status inputs are on pclk; pins are asynchronous
// Notes: apb answers in the first access cycle, no wait state
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "usp_params.svh"
module usp_pin_logic #(
	parameter int unsigned ACT_CYC = `USP_ACT_CYC
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             psel,
	input  wire logic             penable,
	input  wire logic             pwrite,
	input  wire logic [11:0]      paddr,
	input  wire logic [31:0]      pwdata,
	output logic      [31:0]      prdata,
	output logic                  pready,
	output logic                  pslverr,
	input  wire logic             usb_bus_reset,
	input  wire logic             usb_suspended,
	input  wire logic             usb_configured,
	input  wire logic [7:0]       max_power,
	input  wire logic             uart_tx_busy,
	input  wire logic             uart_rx_busy,
	input  wire usp_pkg::usp_pins_t pin_in,
	output usp_pkg::usp_pins_t    pin_out,
	output usp_pkg::usp_pins_t    pin_oe,
	output usp_pkg::usp_pins_t    pin_pu,
	output logic                  bus_status_output,
	output logic                  remote_wake_req,
	output logic [3:0]            modem_in_active
);
	import usp_pkg::*;

	// ==========================================================
	// pin synchronisers
	usp_pins_t pin_s1_r;
	usp_pins_t pin_s2_r;
	usp_pins_t pin_s3_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_s1_r <= `USP_PU_RESET;
			pin_s2_r <= `USP_PU_RESET;
			pin_s3_r <= `USP_PU_RESET;
		end else begin
			pin_s1_r <= pin_in;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
		end
	end

	// ==========================================================
	// registers
	logic [3:0]  stat_cfg_r;
	logic [23:0] func_r;
	usp_pins_t   dir_r;
	usp_pins_t   out_r;
	usp_pins_t   pu_r;
	logic [1:0]  mc_r;
	logic        wr_en;
	logic        rd_ok;
	logic [31:0] rd_nxt;

	assign wr_en = psel & penable & pwrite & pready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_cfg_r <= `USP_SC_RESET;
		end else if (wr_en && paddr == `USP_A_STAT_CFG) begin
			stat_cfg_r <= pwdata[3:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			func_r <= `USP_FUNC_RESET;
		end else if (wr_en && paddr == `USP_A_FUNC_SEL) begin
			func_r <= pwdata[23:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_r <= `USP_DIR_RESET;
			out_r <= `USP_OUT_RESET;
			pu_r  <= `USP_PU_RESET;
			mc_r  <= `USP_MC_RESET;
		end else if (wr_en) begin
			if (paddr == `USP_A_GPIO_DIR) begin
				dir_r <= pwdata[7:0];
			end else if (paddr == `USP_A_GPIO_OUT) begin
				out_r <= pwdata[7:0];
			end else if (paddr == `USP_A_GPIO_PU) begin
				pu_r <= pwdata[7:0];
			end else if (paddr == `USP_A_MODEM_CTL) begin
				mc_r <= pwdata[1:0];
			end
		end
	end

	// ==========================================================
	// apb read decode, data registered at the setup edge
	always_comb begin
		rd_ok  = 1'b1;
		rd_nxt = 32'h0;
		if (paddr == `USP_A_STAT_CFG) begin
			rd_nxt[3:0] = stat_cfg_r;
		end else if (paddr == `USP_A_FUNC_SEL) begin
			rd_nxt[23:0] = func_r;
		end else if (paddr == `USP_A_GPIO_DIR) begin
			rd_nxt[7:0] = dir_r;
		end else if (paddr == `USP_A_GPIO_OUT) begin
			rd_nxt[7:0] = out_r;
		end else if (paddr == `USP_A_GPIO_PU) begin
			rd_nxt[7:0] = pu_r;
		end else if (paddr == `USP_A_GPIO_IN) begin
			rd_nxt[7:0] = pin_s2_r;
		end else if (paddr == `USP_A_MODEM_CTL) begin
			rd_nxt[1:0] = mc_r;
		end else if (paddr == `USP_A_STATUS) begin
			rd_nxt[3:0] = modem_in_active;
			rd_nxt[4]   = bus_status_output;
			rd_nxt[5]   = usb_suspended;
			rd_nxt[6]   = usb_configured;
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~rd_ok;
			if (psel && !penable && !pwrite) begin
				prdata <= rd_nxt;
			end
		end
	end

	// ==========================================================
	// bus status output
	logic high_power;
	logic unsafe;
	logic any_cond;

	// above one unit load the host must configure before full draw
	assign high_power = max_power > `USP_ONE_LOAD;
	assign unsafe     = usb_suspended | (high_power & ~usb_configured);
	assign any_cond   = (stat_cfg_r[`USP_SC_RST] & usb_bus_reset)
	                  | (stat_cfg_r[`USP_SC_SUSP] & usb_suspended)
	                  | (stat_cfg_r[`USP_SC_UNSAFE] & unsafe);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus_status_output <= 1'b0;
		end else begin
			bus_status_output <= any_cond ~^ stat_cfg_r[`USP_SC_POL];
		end
	end

	// ==========================================================
	// activity indicators
	logic rx_tog;
	logic tx_tog;

	usp_act_toggle #(
		.CYC (ACT_CYC)
	) u_rx_act (
		.pclk     (pclk),
		.presetn  (presetn),
		.busy     (uart_rx_busy),
		.toggle_r (rx_tog)
	);

	usp_act_toggle #(
		.CYC (ACT_CYC)
	) u_tx_act (
		.pclk     (pclk),
		.presetn  (presetn),
		.busy     (uart_tx_busy),
		.toggle_r (tx_tog)
	);

	// ==========================================================
	// per-pin function mux
	usp_pins_t pin_out_nxt;
	usp_pins_t pin_oe_nxt;
	usp_pins_t pin_pu_nxt;
	usp_pins_t special;

	// value each modem or activity output pin carries when that function is selected; rs485 on rts carries uart_tx_busy
	always_comb begin
		special              = 8'h00;
		special[`USP_P_RTS]  = ~mc_r[0];
		special[`USP_P_DTR]  = ~mc_r[1];
		special[`USP_P_RXACT] = rx_tog;
		special[`USP_P_TXACT] = tx_tog;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_pin
			usp_fsel_t fs;
			logic      is_out;
			logic      legal_in;
			logic      o_nxt;
			logic      oe_nxt;
			logic      pu_nxt;
			assign fs = usp_fsel_t'(func_r[gi*3 +: 3]);
			// modem inputs sit on pins up to ring; wake only on ring
			assign legal_in = (fs == USP_F_MODEM && gi <= `USP_P_RING)
			                || (fs == USP_F_WAKE && gi == `USP_P_RING);
			// only legal function/pin pairs leave gpio; others fall back
			always_comb begin
				is_out = 1'b0;
				o_nxt  = out_r[gi];
				oe_nxt = dir_r[gi];
				pu_nxt = pu_r[gi];
				if (fs == USP_F_MODEM && (gi == `USP_P_RTS || gi == `USP_P_DTR)) begin
					is_out = 1'b1;
					o_nxt  = special[gi];
				end else if (fs == USP_F_RS485 && gi == `USP_P_RTS) begin
					is_out = 1'b1;
					o_nxt  = uart_tx_busy;
				end else if (fs == USP_F_ACT && (gi == `USP_P_RXACT || gi == `USP_P_TXACT)) begin
					is_out = 1'b1;
					o_nxt  = special[gi];
				end else if (legal_in) begin
					oe_nxt = 1'b0;
					pu_nxt = 1'b1;
				end
				if (is_out) begin
					oe_nxt = 1'b1;
					pu_nxt = 1'b0;
				end
			end
			// one bit per pass keeps each vector bit single-driven
			assign pin_out_nxt[gi] = o_nxt;
			assign pin_oe_nxt[gi]  = oe_nxt;
			assign pin_pu_nxt[gi]  = pu_nxt;
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= `USP_OUT_RESET;
			pin_oe  <= `USP_DIR_RESET;
			pin_pu  <= `USP_PU_RESET;
		end else begin
			pin_out <= pin_out_nxt;
			pin_oe  <= pin_oe_nxt;
			pin_pu  <= pin_pu_nxt;
		end
	end

	// ==========================================================
	// modem inputs and remote wakeup
	usp_fsel_t ring_fs;
	logic      ring_fall;
	logic [3:0] mi_nxt;

	assign ring_fs   = usp_fsel_t'(func_r[`USP_P_RING*3 +: 3]);
	assign ring_fall = pin_s3_r[`USP_P_RING] & ~pin_s2_r[`USP_P_RING];

	always_comb begin
		mi_nxt    = 4'h0;
		mi_nxt[0] = ~pin_s2_r[`USP_P_CTS];
		mi_nxt[1] = ~pin_s2_r[`USP_P_DSR];
		mi_nxt[2] = ~pin_s2_r[`USP_P_CD];
		mi_nxt[3] = ~pin_s2_r[`USP_P_RING];
		if (func_r[`USP_P_CTS*3 +: 3] != USP_F_MODEM) mi_nxt[0] = 1'b0;
		if (func_r[`USP_P_DSR*3 +: 3] != USP_F_MODEM) mi_nxt[1] = 1'b0;
		if (func_r[`USP_P_CD*3 +: 3] != USP_F_MODEM) mi_nxt[2] = 1'b0;
		if (ring_fs != USP_F_MODEM) mi_nxt[3] = 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			modem_in_active <= 4'h0;
			remote_wake_req <= 1'b0;
		end else begin
			modem_in_active <= mi_nxt;
			// resume itself is the usb engine's job; this is its request
			remote_wake_req <= (ring_fs == USP_F_WAKE) & ring_fall;
		end
	end
endmodule

// ==== verification/usp_pin_logic_properties.sv ====
// Purpose: port checker for usp_pin_logic
// Assumes: inputs change just after pclk rises
// Notes: bind after the module
`timescale 1ns/1ps
module usp_chk #(
	parameter int unsigned ACT_CYC = 8
) (
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [31:0]	prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		usb_bus_reset,
	input wire logic		usb_suspended,
	input wire logic		usb_configured,
	input wire logic [7:0]	max_power,
	input wire logic		uart_tx_busy,
	input wire logic		uart_rx_busy,
	input wire usp_pkg::usp_pins_t	pin_in,
	input wire usp_pkg::usp_pins_t	pin_out,
	input wire logic		remote_wake_req,
	input wire logic [3:0]	modem_in_active,
	input wire logic		bus_status_output
);
	import usp_pkg::*;
	// ==========
	// properties
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_wait: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
	a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read gave data");
	a_wake_pulse: assert property (remote_wake_req |=> !remote_wake_req)
		else $error("wake request not a pulse");
	a_wake_cause: assert property (remote_wake_req |-> !$past(pin_in[5], 3)
		&& $past(pin_in[5], 4))
		else $error("wake request without falling edge");
	a_modem_low: assert property (modem_in_active[0] |-> !$past(pin_in[1], 3))
		else $error("modem input active with pin high");
	// status moves at most two cycles after a cause
	a_status_hold: assert property ((!psel && $stable({usb_bus_reset, usb_suspended,
		usb_configured, max_power}))[*2] |=> $stable(bus_status_output))
		else $error("status moved without cause");
	a_pins_hold: assert property ((!psel && !uart_tx_busy && !uart_rx_busy)[*2]
		|=> $stable(pin_out))
		else $error("pin output moved while idle");
	c_status: cover property ($rose(bus_status_output));
	c_wake: cover property (remote_wake_req);
	c_err: cover property (pslverr);
	c_act: cover property ($changed(pin_out[6]));
endmodule
bind usp_pin_logic usp_chk #(.ACT_CYC(ACT_CYC)) chk (.*);

// ==== verification/usp_serial_peer.sv ====
// Purpose: serial peer and pad resolution
// Assumes: peer drives only input pins
// Notes: undriven pin without pull-up shows inverse of last output
`timescale 1ns/1ps
module usp_serial_peer (
	input wire usp_pkg::usp_pins_t	pin_out,
	input wire usp_pkg::usp_pins_t	pin_oe,
	input wire usp_pkg::usp_pins_t	pin_pu,
	input wire usp_pkg::usp_pins_t	peer_lvl,
	input wire usp_pkg::usp_pins_t	peer_en,
	output usp_pkg::usp_pins_t		pin_in
);
	import usp_pkg::*;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (peer_en[i])
				pin_in[i] = peer_lvl[i];
			else if (pin_pu[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = ~pin_out[i];
		end
	end
endmodule

// ==== verification/usp_pin_logic_tb.sv ====
// Purpose: self-checking bench for usp_pin_logic
// Assumes: ACT_CYC of 8 keeps the indicator short
// Notes: apb tasks wait for pready under the timeout
`timescale 1ns/1ps
`include "usp_params.svh"
module usp_pin_logic_tb;
	import usp_pkg::*;
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic		usb_bus_reset, usb_suspended, usb_configured, uart_tx_busy, uart_rx_busy;
	logic		remote_wake_req, bus_status_output;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [7:0]	max_power;
	logic [3:0]	modem_in_active;
	usp_pins_t	pin_in, pin_out, pin_oe, pin_pu, peer_lvl, peer_en, b;
	int		n_errors = 0, tests_run = 0, cyc = 0, k, j;
	// cfg, bus reset, suspend, configured, expected, max power
	logic [15:0]	tbl [9] = '{16'h5532, 16'h5032, 16'h5832, 16'h2832, 16'h2132,
		16'h9032, 16'h9732, 16'h9133, 16'h9233};
	usp_pin_logic #(.ACT_CYC(8)) uut (.*);
	usp_serial_peer peer (.*);
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	// ==========
	// tasks
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// hang guard, run needs well under 1000 cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	// ==========
	// tests
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, uart_tx_busy, uart_rx_busy} = '0;
		{usb_bus_reset, usb_suspended, usb_configured, peer_en} = '0;
		max_power = 8'h32;
		peer_lvl = 8'hff;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check({pin_out, pin_oe, pin_pu}, 24'h0000ff);
		apb(0, `USP_A_STAT_CFG, 0);
		check(rd, 32'h5);
		foreach (tbl[i]) begin
			apb(1, `USP_A_STAT_CFG, tbl[i][15:12]);
			{usb_bus_reset, usb_suspended, usb_configured} <= tbl[i][11:9];
			max_power <= tbl[i][7:0];
			repeat (3) @(posedge pclk);
			check(bus_status_output, tbl[i][8]);
		end
		apb(0, 12'h020, 0);
		check({err, rd}, 33'h100000000);
		apb(1, `USP_A_FUNC_SEL, 32'h918049);
		apb(1, `USP_A_MODEM_CTL, 32'h1);
		@(posedge pclk);
		check({pin_oe[2:0], pin_out[2], pin_out[0]}, 5'b10110);
		peer_lvl <= 8'hdd;
		peer_en <= 8'h22;
		k = 0;
		while (remote_wake_req !== 1'b1 && k < 10) begin
			@(posedge pclk);
			k++;
		end
		check(k < 10, 1);
		@(posedge pclk);
		check(remote_wake_req, 0);
		apb(0, `USP_A_STATUS, 0);
		check(rd[3:0], 4'h1);
		check(modem_in_active, 4'h1);
		apb(1, `USP_A_FUNC_SEL, 32'h91804a);
		uart_tx_busy <= 1'b1;
		repeat (2) @(posedge pclk);
		check({pin_oe[0], pin_out[0]}, 2'b11);
		uart_tx_busy <= 1'b0;
		repeat (2) @(posedge pclk);
		check(pin_out[0], 0);
		for (int p = 0; p < 2; p++) begin
			{uart_tx_busy, uart_rx_busy} <= 2'b01 << p;
			k = 0;
			j = 0;
			b = pin_out;
			repeat (36) begin
				@(posedge pclk);
				k += pin_out[6+p] ^ b[6+p];
				j += pin_out[7-p] ^ b[7-p];
				b = pin_out;
			end
			check({k >= 4 && k <= 5, j[7:0]}, 9'h100);
		end
		{uart_tx_busy, uart_rx_busy} <= 2'b00;
		apb(1, `USP_A_GPIO_DIR, 32'h8);
		apb(1, `USP_A_GPIO_OUT, 32'h8);
		@(posedge pclk);
		check({pin_oe[3], pin_out[3]}, 2'b11);
		apb(1, `USP_A_GPIO_OUT, 32'h0);
		repeat (2) @(posedge pclk);
		apb(0, `USP_A_GPIO_IN, 0);
		check({pin_oe[3], pin_out[3], rd[3]}, 3'b100);
		report_and_stop();
	end
endmodule
